// [logic/pss_cfg.svh]
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// clock and converter switching rate, in kHz
`define PSS_CLK_KHZ 25000
`define PSS_SW_FREQ_KHZ 2000
// switching period in clock cycles, rounded down
`define PSS_SW_PERIOD_CYC (`PSS_CLK_KHZ / `PSS_SW_FREQ_KHZ)
// one third of a period between converter turn-on points
`define PSS_PHASE_STEP_CYC (`PSS_SW_PERIOD_CYC / 3)
`define PSS_PHASE_W 4

// startup sequence duration in microseconds, and in cycles
`define PSS_SEQ_US 1
`define PSS_SEQ_CYC (`PSS_SEQ_US * `PSS_CLK_KHZ / 1000)
`define PSS_SEQ_W 5

// reset values
`define PSS_RST_BUCK_EN 3'h0
`define PSS_RST_POR 1'h0

// buck enable bit positions
`define PSS_BUCK1_BIT 0
`define PSS_BUCK2_BIT 1
`define PSS_BUCK3_BIT 2

`endif

// [logic/pss_pkg.sv]
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_ST_STARTUP,
    PSS_ST_ACTIVE,
    PSS_ST_SLEEP,
    PSS_ST_SHUTDOWN
  } pss_state_t;

  typedef enum logic [1:0] {
    PSS_CMD_RESET,
    PSS_CMD_SLEEP,
    PSS_CMD_WAKEUP,
    PSS_CMD_SHUTDOWN
  } pss_cmd_t;

endpackage

// [logic/pss_phase.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"

module pss_phase (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] en,
  output logic [2:0] phase_on
);

  typedef struct packed {
    logic [`PSS_PHASE_W-1:0] cnt;
    logic [2:0] phase_on;
  } pss_phase_reg_t;

  localparam logic [`PSS_PHASE_W-1:0] LAST = `PSS_PHASE_W'(`PSS_SW_PERIOD_CYC - 1);

  pss_phase_reg_t s;
  pss_phase_reg_t next_s;

  always_comb begin
    next_s = s;
    next_s.cnt = (s.cnt == LAST) ? '0 : s.cnt + 4'h1;
    // each converter turns on a third of a period after the previous one [R17]
    for (int i = 0; i < 3; i++) begin
      next_s.phase_on[i] = en[i] && (s.cnt == `PSS_PHASE_W'(i * `PSS_PHASE_STEP_CYC));
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign phase_on = s.phase_on;

endmodule

`default_nettype wire

// [logic/pss_seq.sv]
// How it works
// R1 - power-up lands in Startup
// R2 - Startup: converters off, reset output low
// R3 - enable low leads into Startup
// R4 - Startup runs sequence alone, then Active
// R5 - Reset command in Startup restarts sequence
// R6 - Active: all converters on, reset high
// R7 - Active: enable low or Reset to Startup
// R8 - Active: Sleep command goes to Sleep
// R9 - Active or Sleep: Shutdown command to Shutdown
// R10 - Sleep: only converter 1 off, reset high
// R11 - Sleep: Wakeup to Active, defaults restored
// R12 - Sleep: enable low or Reset to Startup
// R13 - Shutdown: all converters off, reset low
// R14 - enable held low also reaches Shutdown
// R15 - enable going high leaves Shutdown
// R16 - Reset command leaves Shutdown for Startup
// R17 - converters switch a third period apart
// R18 - commands without a transition are ignored
`timescale 1ns/1ps
`default_nettype none
`include "pss_cfg.svh"

module pss_seq (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic ENABLE,
  input wire logic CMD_VALID,
  input wire logic [1:0] CMD_CODE,
  output logic BUCK1_EN,
  output logic BUCK2_EN,
  output logic BUCK3_EN,
  output logic SYS_RESET_N,
  output logic CFG_DEFAULT,
  output logic [1:0] STATE,
  output logic [2:0] PHASE_ON
);

  localparam logic [`PSS_SEQ_W-1:0] SEQ_LAST = `PSS_SEQ_W'(`PSS_SEQ_CYC - 1);

  typedef struct packed {
    pss_pkg::pss_state_t state;
    logic en_meta;
    logic en_sync;
    logic en_prev;
    logic [`PSS_SEQ_W-1:0] seq_cnt;
    logic [2:0] buck_en;
    logic por;
    logic cfg_default;
  } pss_seq_reg_t;

  pss_seq_reg_t s;
  pss_seq_reg_t next_s;

  logic en_fall;
  logic en_rise;
  logic cmd_reset;
  logic cmd_sleep;
  logic cmd_wakeup;
  logic cmd_shutdown;

  // converter enables for a state; bit 0 is converter 1
  function automatic logic [2:0] buck_mask(input pss_pkg::pss_state_t st);
    logic [2:0] m;
    m = 3'h0;
    unique case (st)
      pss_pkg::PSS_ST_STARTUP: m = 3'h0;
      pss_pkg::PSS_ST_ACTIVE: m = 3'h7;
      pss_pkg::PSS_ST_SLEEP: m = 3'h6;
      pss_pkg::PSS_ST_SHUTDOWN: m = 3'h0;
    endcase
    return m;
  endfunction

  // system reset output level for a state
  function automatic logic por_level(input pss_pkg::pss_state_t st);
    return (st == pss_pkg::PSS_ST_ACTIVE) || (st == pss_pkg::PSS_ST_SLEEP);
  endfunction

  // only the synchronised copies are looked at; en_meta feeds en_sync alone
  assign en_fall = s.en_prev && !s.en_sync;
  assign en_rise = !s.en_prev && s.en_sync;

  assign cmd_reset = CMD_VALID && (CMD_CODE == pss_pkg::PSS_CMD_RESET);
  assign cmd_sleep = CMD_VALID && (CMD_CODE == pss_pkg::PSS_CMD_SLEEP);
  assign cmd_wakeup = CMD_VALID && (CMD_CODE == pss_pkg::PSS_CMD_WAKEUP);
  assign cmd_shutdown = CMD_VALID && (CMD_CODE == pss_pkg::PSS_CMD_SHUTDOWN);

  always_comb begin
    next_s = s;
    next_s.en_meta = ENABLE;
    next_s.en_sync = s.en_meta;
    next_s.en_prev = s.en_sync;
    next_s.cfg_default = 1'b0;
    unique case (s.state)
      pss_pkg::PSS_ST_STARTUP: begin
        if (cmd_reset || en_fall) begin
          // abandon the running sequence and begin again [R5] [R3]
          next_s.seq_cnt = '0;
        end else if (s.seq_cnt == SEQ_LAST) begin
          next_s.seq_cnt = '0;
          if (s.en_sync) begin
            // sequence done, no host action needed [R4]
            next_s.state = pss_pkg::PSS_ST_ACTIVE;
            next_s.cfg_default = 1'b1;
          end else begin
            // enable still low once the sequence ends [R14]
            next_s.state = pss_pkg::PSS_ST_SHUTDOWN;
          end
        end else begin
          next_s.seq_cnt = s.seq_cnt + 5'h01; // [R4]
        end
      end
      pss_pkg::PSS_ST_ACTIVE: begin
        if (en_fall || cmd_reset) begin
          next_s.state = pss_pkg::PSS_ST_STARTUP; // [R7] [R3]
          next_s.seq_cnt = '0;
        end else if (cmd_sleep) begin
          next_s.state = pss_pkg::PSS_ST_SLEEP; // [R8]
        end else if (cmd_shutdown) begin
          next_s.state = pss_pkg::PSS_ST_SHUTDOWN; // [R9]
        end
        // a wakeup here has nowhere to go and is dropped [R18]
      end
      pss_pkg::PSS_ST_SLEEP: begin
        if (en_fall || cmd_reset) begin
          next_s.state = pss_pkg::PSS_ST_STARTUP; // [R12] [R3]
          next_s.seq_cnt = '0;
        end else if (cmd_wakeup) begin
          // defaults come back, so firmware must reprogram voltages [R11]
          next_s.state = pss_pkg::PSS_ST_ACTIVE;
          next_s.cfg_default = 1'b1;
        end else if (cmd_shutdown) begin
          next_s.state = pss_pkg::PSS_ST_SHUTDOWN; // [R9]
        end
        // a second sleep is dropped [R18]
      end
      pss_pkg::PSS_ST_SHUTDOWN: begin
        if (en_rise || cmd_reset) begin
          next_s.state = pss_pkg::PSS_ST_STARTUP; // [R15] [R16]
          next_s.seq_cnt = '0;
        end
        // sleep, wakeup and shutdown are dropped here [R18]
      end
    endcase
    // outputs follow the state being entered, so they switch with it
    next_s.buck_en = buck_mask(next_s.state); // [R2] [R6] [R10] [R13]
    next_s.por = por_level(next_s.state); // [R2] [R6] [R10] [R13]
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      // power-up state is Startup with everything held off [R1]
      s.state <= pss_pkg::PSS_ST_STARTUP;
      s.en_meta <= 1'b0;
      s.en_sync <= 1'b0;
      s.en_prev <= 1'b0;
      s.seq_cnt <= '0;
      s.buck_en <= `PSS_RST_BUCK_EN;
      s.por <= `PSS_RST_POR;
      s.cfg_default <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  pss_phase u_phase (
    .clk(CLK),
    .reset_n(RESET_N),
    .en(s.buck_en),
    .phase_on(PHASE_ON)
  );

  assign BUCK1_EN = s.buck_en[`PSS_BUCK1_BIT];
  assign BUCK2_EN = s.buck_en[`PSS_BUCK2_BIT];
  assign BUCK3_EN = s.buck_en[`PSS_BUCK3_BIT];
  assign SYS_RESET_N = s.por;
  assign CFG_DEFAULT = s.cfg_default;
  assign STATE = s.state;

  // checks

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);

  int unsigned seq_run;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      seq_run <= 0;
    end else if (s.state == pss_pkg::PSS_ST_STARTUP && !cmd_reset && !en_fall) begin
      // a restart zeroes the sequence, so the bound starts over with it
      seq_run <= seq_run + 1;
    end else begin
      seq_run <= 0;
    end
  end

  first_state_a: assert property ($rose(RESET_N) |-> s.state == pss_pkg::PSS_ST_STARTUP) // [R1]
    else $error("not in startup after reset release");

  startup_outs_a: assert property (s.state == pss_pkg::PSS_ST_STARTUP |->
      s.buck_en == 3'h0 && !s.por) // [R2]
    else $error("startup must hold converters off and reset low");

  enable_fall_a: assert property (en_fall && s.state != pss_pkg::PSS_ST_SHUTDOWN |=>
      s.state == pss_pkg::PSS_ST_STARTUP) // [R3]
    else $error("enable low did not lead to startup");

  seq_done_a: assert property (s.state == pss_pkg::PSS_ST_STARTUP && s.seq_cnt == SEQ_LAST &&
      !cmd_reset && !en_fall && s.en_sync |=> s.state == pss_pkg::PSS_ST_ACTIVE && s.cfg_default)
    // [R4]
    else $error("startup sequence did not complete into active");

  seq_restart_a: assert property (s.state == pss_pkg::PSS_ST_STARTUP && cmd_reset |=>
      s.state == pss_pkg::PSS_ST_STARTUP && s.seq_cnt == '0) // [R5]
    else $error("reset in startup did not restart the sequence");

  active_outs_a: assert property (s.state == pss_pkg::PSS_ST_ACTIVE |->
      s.buck_en == 3'h7 && s.por) // [R6]
    else $error("active outputs wrong");

  active_exit_a: assert property (s.state == pss_pkg::PSS_ST_ACTIVE && cmd_reset |=>
      s.state == pss_pkg::PSS_ST_STARTUP ##1 s.state == pss_pkg::PSS_ST_STARTUP) // [R7]
    else $error("reset from active did not reach startup");

  to_sleep_a: assert property (s.state == pss_pkg::PSS_ST_ACTIVE && cmd_sleep && !cmd_reset &&
      !en_fall |=> s.state == pss_pkg::PSS_ST_SLEEP) // [R8]
    else $error("sleep command ignored in active");

  to_shutdown_a: assert property ((s.state == pss_pkg::PSS_ST_ACTIVE ||
      s.state == pss_pkg::PSS_ST_SLEEP) && cmd_shutdown && !en_fall |=>
      s.state == pss_pkg::PSS_ST_SHUTDOWN) // [R9]
    else $error("shutdown command not taken");

  sleep_outs_a: assert property (s.state == pss_pkg::PSS_ST_SLEEP |->
      !s.buck_en[0] && s.buck_en[2:1] == 2'h3 && s.por) // [R10]
    else $error("sleep outputs wrong");

  wake_a: assert property (s.state == pss_pkg::PSS_ST_SLEEP && cmd_wakeup && !en_fall |=>
      s.state == pss_pkg::PSS_ST_ACTIVE && s.cfg_default ##1 !s.cfg_default) // [R11]
    else $error("wakeup did not restore active with defaults");

  sleep_exit_a: assert property (s.state == pss_pkg::PSS_ST_SLEEP && (en_fall || cmd_reset) |=>
      s.state == pss_pkg::PSS_ST_STARTUP && !s.por) // [R12]
    else $error("sleep did not fall back to startup");

  shut_outs_a: assert property (s.state == pss_pkg::PSS_ST_SHUTDOWN |->
      s.buck_en == 3'h0 && !s.por) // [R13]
    else $error("shutdown outputs wrong");

  enable_low_a: assert property (s.state == pss_pkg::PSS_ST_STARTUP && !s.en_sync &&
      s.seq_cnt == SEQ_LAST && !cmd_reset && !en_fall |=> s.state == pss_pkg::PSS_ST_SHUTDOWN)
    // [R14]
    else $error("enable held low did not reach shutdown");

  shut_exit_a: assert property (s.state == pss_pkg::PSS_ST_SHUTDOWN && (en_rise || cmd_reset)
      |=> s.state == pss_pkg::PSS_ST_STARTUP) // [R15] [R16]
    else $error("shutdown not left on enable rise or reset");

  phase_gap_a: assert property (s.state == pss_pkg::PSS_ST_ACTIVE && PHASE_ON[0] &&
      $stable(s.buck_en) |-> ##(`PSS_PHASE_STEP_CYC) (PHASE_ON[1] || s.buck_en != 3'h7)) // [R17]
    else $error("converter 2 not a third period after converter 1");

  ignored_cmd_a: assert property (s.state == pss_pkg::PSS_ST_SHUTDOWN && !cmd_reset &&
      !en_rise |=> $stable(s.state) && $stable(s.por)) // [R18]
    else $error("ignored command changed state");

  seq_bound_a: assert property (seq_run <= `PSS_SEQ_CYC + 2 || !s.en_sync) // [R4]
    else $error("startup lasted too long with enable high");

  boot_c: cover property (s.state == pss_pkg::PSS_ST_STARTUP ##1 s.state == pss_pkg::PSS_ST_ACTIVE);
  sleep_wake_c: cover property (s.state == pss_pkg::PSS_ST_SLEEP ##1
      s.state == pss_pkg::PSS_ST_ACTIVE);
  shut_reset_c: cover property (s.state == pss_pkg::PSS_ST_SHUTDOWN && cmd_reset);
  restart_c: cover property (s.state == pss_pkg::PSS_ST_STARTUP && cmd_reset && s.seq_cnt != '0);

endmodule

`default_nettype wire

// [verif/pss_host.sv]
`timescale 1ns/1ps
`default_nettype none
module pss_host (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic req,
  input wire logic [1:0] req_code,
  output logic cmd_valid,
  output logic [1:0] cmd_code
);
  // command valid is req registered one cycle later; code toggles when idle so a stale code never looks valid
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_valid <= 1'h0;
      cmd_code <= 2'h0;
    end else begin
      cmd_valid <= req;
      cmd_code <= req ? req_code : ~cmd_code;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_power_state_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_power_state_sequencer;
  localparam logic [1:0] ST = pss_pkg::PSS_ST_STARTUP;
  localparam logic [1:0] AC = pss_pkg::PSS_ST_ACTIVE;
  localparam logic [1:0] SL = pss_pkg::PSS_ST_SLEEP;
  localparam logic [1:0] SD = pss_pkg::PSS_ST_SHUTDOWN;
  localparam logic [1:0] CR = pss_pkg::PSS_CMD_RESET;
  localparam logic [1:0] CS = pss_pkg::PSS_CMD_SLEEP;
  localparam logic [1:0] CW = pss_pkg::PSS_CMD_WAKEUP;
  localparam logic [1:0] CD = pss_pkg::PSS_CMD_SHUTDOWN;
  typedef struct packed {logic [1:0] cmd; logic [1:0] exp; logic w;} pss_row_t;
  logic CLK = 1'h0, RESET_N = 1'h0, ENABLE = 1'h1, req = 1'h0;
  logic [1:0] req_code = 2'h0;
  logic cmd_valid, b1, b2, b3, sr, cfg;
  logic [1:0] cmd_code, STATE;
  logic [2:0] PHASE_ON;
  int mismatches = 0, checks_done = 0;
  pss_row_t rows[16] = '{'{CS, SL, 1'h1}, '{CS, SL, 1'h0}, '{CW, AC, 1'h0},
    '{CW, AC, 1'h0}, '{CD, SD, 1'h0}, '{CS, SD, 1'h0}, '{CW, SD, 1'h0},
    '{CR, ST, 1'h0}, '{CR, ST, 1'h0}, '{CD, ST, 1'h0}, '{CS, SL, 1'h1},
    '{CD, SD, 1'h0}, '{CR, ST, 1'h0}, '{CS, SL, 1'h1}, '{CR, ST, 1'h0},
    '{CR, ST, 1'h1}};

  initial begin
    forever #20 CLK = ~CLK;
  end

  pss_host host (.clk(CLK), .reset_n(RESET_N), .req(req), .req_code(req_code),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  pss_seq dut (.CLK(CLK), .RESET_N(RESET_N), .ENABLE(ENABLE), .CMD_VALID(cmd_valid),
    .CMD_CODE(cmd_code), .BUCK1_EN(b1), .BUCK2_EN(b2), .BUCK3_EN(b3), .SYS_RESET_N(sr),
    .CFG_DEFAULT(cfg), .STATE(STATE), .PHASE_ON(PHASE_ON));

  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [3:0] outs_of(input logic [1:0] s);
    return (s == AC) ? 4'hf : (s == SL) ? 4'hd : 4'h0;
  endfunction

  task automatic check_st(input logic [1:0] s);
    chk("state", {2'h0, STATE}, {2'h0, s});
    chk("outputs", {b3, b2, b1, sr}, outs_of(s));
  endtask

  // bounded wait; first Active cycle must carry the defaults pulse
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    while (STATE !== s && n < 60) begin
      @(posedge CLK);
      #1;
      n++;
    end
    check_st(s);
    if (s == AC) chk("cfg_default", {3'h0, cfg}, 4'h1);
  endtask

  task automatic send(input logic [1:0] c);
    req = 1'h1;
    req_code = c;
    @(posedge CLK);
    #1 req = 1'h0;
    @(posedge CLK);
    #1;
  endtask

  task automatic phase(input logic [2:0] m);
    int pos[3];
    int cnt[3];
    cnt = '{0, 0, 0};
    pos = '{0, 0, 0};
    repeat (2) @(posedge CLK);
    for (int i = 0; i < 12; i++) begin
      @(posedge CLK);
      #1;
      for (int b = 0; b < 3; b++) begin
        if (PHASE_ON[b] === 1'h1) begin
          cnt[b]++;
          pos[b] = i;
        end
      end
    end
    for (int b = 0; b < 3; b++) chk("phase_count", 4'(cnt[b]), {3'h0, m[b]});
    if (m == 3'h7) begin
      chk("phase_gap01", 4'((pos[1] - pos[0] + 12) % 12), 4'h4);
      chk("phase_gap12", 4'((pos[2] - pos[1] + 12) % 12), 4'h4);
    end
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #100us;
    mismatches++;
    complete_run;
  end

  initial begin
    logic [1:0] prev;
    repeat (16) @(posedge CLK);
    #1 RESET_N = 1'h1;
    check_st(ST);
    for (int r = 0; r < 16; r++) begin
      if (rows[r].w) wait_st(AC);
      prev = STATE;
      send(rows[r].cmd);
      check_st(rows[r].exp);
      chk("cfg_cmd", {3'h0, cfg}, {3'h0, rows[r].exp == AC && prev != AC});
    end
    wait_st(AC);
    phase(3'h7);
    send(CS);
    phase(3'h6);
    send(CR);
    repeat (20) @(posedge CLK);
    send(CR);
    repeat (20) @(posedge CLK);
    #1 check_st(ST);
    wait_st(AC);
    ENABLE = 1'h0;
    repeat (4) @(posedge CLK);
    #1 check_st(ST);
    wait_st(SD);
    ENABLE = 1'h1;
    wait_st(ST);
    wait_st(AC);
    send(CS);
    ENABLE = 1'h0;
    repeat (4) @(posedge CLK);
    #1 check_st(ST);
    wait_st(SD);
    ENABLE = 1'h1;
    wait_st(ST);
    wait_st(AC);
    // back-to-back: Sleep then Shutdown on consecutive cycles
    req = 1'h1;
    req_code = CS;
    @(posedge CLK);
    #1 req_code = CD;
    @(posedge CLK);
    #1 req = 1'h0;
    check_st(SL);
    @(posedge CLK);
    #1 check_st(SD);
    RESET_N = 1'h0;
    #5 check_st(ST);
    @(posedge CLK);
    #1 RESET_N = 1'h1;
    wait_st(AC);
    complete_run;
  end
endmodule
`default_nettype wire
